//--- hw/tdbc_counter_top.sv
// Summary of operation
// - Three BCD decades step on count-clock falling edge, carried synchronously.
// - Each decade feeds its own four-bit holding latch.
// - Latched digits leave time-shared on one active-high four-bit output.
// - One active-low select per digit, low while that digit is shown.
// - Scan steps on internal divider or an overriding external scan clock.
// - Overflow gives one pulse per thousand counts, at wrap.
// - Master reset clears all decades and restarts the digit scanner.
// - During master reset scanner sits on digit one, all selects high.
// - Scan clock generator stopped while master reset is high.
// - Disable high blocks count edges; counters keep their value.
// - Latch enable rising captures the count, held while high.
// - Latched count survives reset when latch enable stays high throughout.
`timescale 1ns/1ps
`default_nettype none

`include "tdbc_regs.svh"

module tdbc_counter_top
   import tdbc_pkg::*;
(
   // Clock, reset, enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Counter inputs
   input wire logic count_clk,
   input wire logic count_disable,
   input wire logic master_reset,
   input wire logic latch_enable,
   input wire logic ext_scan_clk,
   // Display and cascade outputs
   output logic [3:0] bcd_out,
   output logic [2:0] digit_sel_n,
   output logic overflow
);

   // Bus state
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic [31:0] hrdata_r;
   logic [31:0] rd_data;
   logic addr_ok;

   // Software registers
   logic [3:0] ctrl_r;
   logic [15:0] scan_div_r;
   logic [15:0] wraps_r;
   logic [15:0] wraps_nxt;
   logic wraps_clr;

   // Counter datapath
   logic cnt_clk_q_r;
   logic cnt_fall;
   logic cnt_step;
   logic carry_out;
   tdbc_count_t cnt_r;
   tdbc_count_t cnt_nxt;
   tdbc_count_t latch_r;
   logic [3:0] bcd_out_r;
   logic overflow_r;

   // Effective controls, pin or software
   logic mr_eff;
   logic dis_eff;
   logic le_eff;

   tdbc_scan_if sif ();

   // Codes above nine fold back to zero
   function automatic tdbc_bcd_t bcd_inc(input tdbc_bcd_t d);
      if (d >= `TDBC_BCD_MAX) begin
         bcd_inc = `TDBC_DIGIT_RST;
      end else begin
         bcd_inc = d + 4'h1;
      end
   endfunction

   function automatic logic bcd_top(input tdbc_bcd_t d);
      bcd_top = (d >= `TDBC_BCD_MAX);
   endfunction

   // Hundreds in [11:8], tens in [7:4], units in [3:0]
   function automatic logic [31:0] pad12(input tdbc_count_t c);
      pad12 = {20'h00000, c[2], c[1], c[0]};
   endfunction

   function automatic logic wr_hit(input logic [7:0] ofs);
      wr_hit = wr_pend_r && (wr_addr_r == ofs);
   endfunction

   // Soft controls OR with the pins; either one asserts
   assign mr_eff = master_reset | ctrl_r[`TDBC_CTRL_MR_BIT];
   assign dis_eff = count_disable | ctrl_r[`TDBC_CTRL_DIS_BIT];
   assign le_eff = latch_enable | ctrl_r[`TDBC_CTRL_LE_BIT];

   // ---- AHB-Lite slave, zero wait state ----
   // Every transfer completes at once with OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;
   // Only the low address byte decodes; the map repeats
   assign addr_ok = hsel & htrans[1] & hready;

   // Address phase latches write target
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else if (ce) begin
         wr_pend_r <= addr_ok & hwrite & (hsize == `TDBC_HSIZE_WORD);
         wr_addr_r <= haddr[7:0];
      end
   end

   always_comb begin
      rd_data = 32'h00000000;
      case (haddr[7:0])
         `TDBC_CTRL_OFS: rd_data = {28'h0000000, ctrl_r};
         `TDBC_SCAN_DIV_OFS: rd_data = {16'h0000, scan_div_r};
         `TDBC_COUNT_OFS: rd_data = pad12(cnt_r);
         `TDBC_LATCH_OFS: rd_data = pad12(latch_r);
         // Effective levels, pin or software
         `TDBC_STATUS_OFS: begin
            rd_data[`TDBC_STAT_MR_BIT] = mr_eff;
            rd_data[`TDBC_STAT_DIS_BIT] = dis_eff;
            rd_data[`TDBC_STAT_LE_BIT] = le_eff;
            rd_data[`TDBC_STAT_PTR_LSB +: 2] = sif.ptr;
            rd_data[`TDBC_STAT_SEL_LSB +: 3] = sif.sel_n;
         end
         `TDBC_WRAPS_OFS: rd_data = {16'h0000, wraps_r};
         default: rd_data = 32'h00000000;
      endcase
   end

   // Read data sampled in the address phase
   // Holds until the next read, so idle cycles keep it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h00000000;
      end else if (ce) begin
         if (addr_ok & ~hwrite) begin
            hrdata_r <= rd_data;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= `TDBC_CTRL_RST;
      end else if (ce) begin
         // Bits above the four controls are dropped
         if (wr_hit(`TDBC_CTRL_OFS)) begin
            ctrl_r <= hwdata[3:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scan_div_r <= `TDBC_SCAN_DIV_RST;
      end else if (ce) begin
         if (wr_hit(`TDBC_SCAN_DIV_OFS)) begin
            scan_div_r <= hwdata[15:0];
         end
      end
   end

   // ---- Decade counters ----
   // Count clock is taken as synchronous; a falling edge is one step
   // Resets low so a pin idling low gives no false count
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_clk_q_r <= 1'b0;
      end else if (ce) begin
         cnt_clk_q_r <= count_clk;
      end
   end

   assign cnt_fall = cnt_clk_q_r & ~count_clk;

   assign cnt_step = cnt_fall & ~dis_eff;

   // synchronous carry chain
   // A decade steps only when every lower one sits at nine
   always_comb begin
      logic carry;
      carry = cnt_step;
      cnt_nxt = cnt_r;
      for (int i = 0; i < 3; i++) begin
         if (carry) begin
            cnt_nxt[i] = bcd_inc(cnt_r[i]);
         end
         carry = carry & bcd_top(cnt_r[i]);
      end
      carry_out = carry;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= '0;
      end else if (ce) begin
         if (mr_eff) begin
            cnt_r <= '0;
         end else begin
            cnt_r <= cnt_nxt;
         end
      end
   end

   // one pulse per wrap
   // Held off in reset so a clear never fakes a wrap
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         overflow_r <= 1'b0;
      end else if (ce) begin
         overflow_r <= carry_out & ~mr_eff;
      end
   end

   // Wrap tally; a wrap in the clearing cycle still counts
   assign wraps_clr = wr_hit(`TDBC_WRAPS_OFS);

   always_comb begin
      wraps_nxt = wraps_clr ? `TDBC_WRAPS_RST : wraps_r;
      if (carry_out & ~mr_eff) begin
         wraps_nxt = wraps_nxt + 16'h0001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wraps_r <= `TDBC_WRAPS_RST;
      end else if (ce) begin
         wraps_r <= wraps_nxt;
      end
   end

   // ---- Holding latches ----
   // per-decade holding latch
   // reset ignored while holding
   // Capture is the count of the last cycle before enable rose
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         latch_r <= '0;
      end else if (ce) begin
         if (!le_eff) begin
            latch_r <= cnt_r;
         end
      end
   end

   // ---- Scanner and multiplexer ----
   // Scan keeps running while counting is disabled
   assign sif.mr = mr_eff;
   assign sif.ext_sel = ctrl_r[`TDBC_CTRL_EXT_BIT];
   assign sif.ext_clk = ext_scan_clk;
   assign sif.div = scan_div_r;

   tdbc_scan u_scan (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .sif(sif.scanner)
   );

   // one digit on shared bus
   // Registered so data lines up with the registered selects
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bcd_out_r <= `TDBC_DIGIT_RST;
      end else if (ce) begin
         case (sif.ptr)
            TDBC_DIG1: bcd_out_r <= latch_r[0];
            TDBC_DIG2: bcd_out_r <= latch_r[1];
            TDBC_DIG3: bcd_out_r <= latch_r[2];
            default: bcd_out_r <= `TDBC_DIGIT_RST;
         endcase
      end
   end

   assign digit_sel_n = sif.sel_n;
   assign bcd_out = bcd_out_r;
   assign overflow = overflow_r;

endmodule

`default_nettype wire

//--- hw/tdbc_regs.svh
`ifndef TDBC_REGS_SVH
`define TDBC_REGS_SVH

// Register byte offsets
`define TDBC_CTRL_OFS 8'h00
`define TDBC_SCAN_DIV_OFS 8'h04
`define TDBC_COUNT_OFS 8'h08
`define TDBC_LATCH_OFS 8'h0C
`define TDBC_STATUS_OFS 8'h10
`define TDBC_WRAPS_OFS 8'h14

// Control field positions
`define TDBC_CTRL_MR_BIT 0
`define TDBC_CTRL_DIS_BIT 1
`define TDBC_CTRL_LE_BIT 2
`define TDBC_CTRL_EXT_BIT 3

// Status field positions
`define TDBC_STAT_MR_BIT 0
`define TDBC_STAT_DIS_BIT 1
`define TDBC_STAT_LE_BIT 2
`define TDBC_STAT_PTR_LSB 4
`define TDBC_STAT_SEL_LSB 8

// Reset values
`define TDBC_CTRL_RST 4'h0
`define TDBC_SCAN_DIV_RST 16'h0FA0
`define TDBC_WRAPS_RST 16'h0000
`define TDBC_DIGIT_RST 4'h0
`define TDBC_SEL_IDLE 3'h7

// Decade limit and bus word size
`define TDBC_BCD_MAX 4'h9
`define TDBC_HSIZE_WORD 3'h2

`endif

//--- hw/tdbc_pkg.sv
`default_nettype none

package tdbc_pkg;

   typedef logic [3:0] tdbc_bcd_t;
   typedef logic [2:0][3:0] tdbc_count_t;
   typedef enum logic [1:0] {TDBC_DIG1, TDBC_DIG2, TDBC_DIG3} tdbc_digit_e;

endpackage

`default_nettype wire

//--- hw/tdbc_scan_if.sv
`timescale 1ns/1ps
`default_nettype none

interface tdbc_scan_if;
   import tdbc_pkg::*;
   logic mr;
   logic ext_sel;
   logic ext_clk;
   logic [15:0] div;
   tdbc_digit_e ptr;
   logic [2:0] sel_n;

   modport scanner (input mr, input ext_sel, input ext_clk, input div,
                    output ptr, output sel_n);
   modport core (output mr, output ext_sel, output ext_clk, output div,
                 input ptr, input sel_n);
endinterface

`default_nettype wire

//--- hw/tdbc_scan.sv
`timescale 1ns/1ps
`default_nettype none

`include "tdbc_regs.svh"

module tdbc_scan
   import tdbc_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   // Scan link to the core
   tdbc_scan_if.scanner sif
);

   logic [15:0] div_cnt_r;
   logic [15:0] div_cnt_nxt;
   logic ext_q_r;
   logic int_tick;
   logic ext_rise;
   logic step;
   tdbc_digit_e ptr_r;
   tdbc_digit_e ptr_nxt;
   logic [2:0] sel_n_r;

   function automatic logic [2:0] dig_sel_n(input tdbc_digit_e d);
      case (d)
         TDBC_DIG1: dig_sel_n = 3'h6;
         TDBC_DIG2: dig_sel_n = 3'h5;
         TDBC_DIG3: dig_sel_n = 3'h3;
         default: dig_sel_n = `TDBC_SEL_IDLE;
      endcase
   endfunction

   // Divider of zero behaves as one
   assign int_tick = (div_cnt_r + 16'h0001 >= sif.div);
   assign ext_rise = sif.ext_clk & ~ext_q_r;

   assign step = sif.ext_sel ? ext_rise : int_tick;

   always_comb begin
      div_cnt_nxt = div_cnt_r + 16'h0001;
      if (int_tick) begin
         div_cnt_nxt = 16'h0000;
      end
   end

   always_comb begin
      case (ptr_r)
         TDBC_DIG1: ptr_nxt = TDBC_DIG2;
         TDBC_DIG2: ptr_nxt = TDBC_DIG3;
         TDBC_DIG3: ptr_nxt = TDBC_DIG1;
         default: ptr_nxt = TDBC_DIG1;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_q_r <= 1'b0;
      end else if (ce) begin
         ext_q_r <= sif.ext_clk;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_cnt_r <= 16'h0000;
      end else if (ce) begin
         div_cnt_r <= sif.mr ? 16'h0000 : div_cnt_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ptr_r <= TDBC_DIG1;
      end else if (ce) begin
         if (sif.mr) begin
            ptr_r <= TDBC_DIG1;
         end else if (step) begin
            ptr_r <= ptr_nxt;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_n_r <= `TDBC_SEL_IDLE;
      end else if (ce) begin
         sel_n_r <= sif.mr ? `TDBC_SEL_IDLE : dig_sel_n(ptr_r);
      end
   end

   assign sif.ptr = ptr_r;
   assign sif.sel_n = sel_n_r;

endmodule

`default_nettype wire

//--- test/tdbc_disp_model.sv
`timescale 1ns/1ps
`default_nettype none

module tdbc_disp_model
   import tdbc_pkg::*;
(
   // Clock
   input wire logic hclk,
   // Display side
   input wire logic [3:0] bcd_out,
   input wire logic [2:0] digit_sel_n,
   input wire logic overflow,
   // External scan source
   input wire logic ext_run,
   output logic ext_scan_clk,
   // Observations
   output tdbc_count_t shown,
   output int steps,
   output int wraps
);
   int div_q = 0;
   logic clk_q = 1'b0;
   logic [2:0] sel_q = 3'h7;
   tdbc_count_t shown_q = '0;
   int steps_q = 0;
   int wraps_q = 0;

   assign ext_scan_clk = clk_q;
   assign shown = shown_q;
   assign steps = steps_q;
   assign wraps = wraps_q;

   // overriding scan clock
   // Stands low between runs, no stray edges
   always @(posedge hclk) begin
      div_q <= ext_run ? (div_q + 1) % 4 : 0;
      if (!ext_run)
         clk_q <= 1'b0;
      else if (div_q == 3)
         clk_q <= ~clk_q;
   end

   always @(posedge hclk) begin
      sel_q <= digit_sel_n;
      if (digit_sel_n != sel_q)
         steps_q <= steps_q + 1;
      if (overflow)
         wraps_q <= wraps_q + 1;
      for (int i = 0; i < 3; i++)
         if (digit_sel_n == ~(3'h1 << i))
            shown_q[i] <= bcd_out;
   end
endmodule

`default_nettype wire

//--- test/tdbc_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module tdbc_checker (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Counter controls
   input wire logic count_clk,
   input wire logic count_disable,
   input wire logic master_reset,
   input wire logic latch_enable,
   // Display and cascade
   input wire logic [3:0] bcd_out,
   input wire logic [2:0] digit_sel_n,
   input wire logic overflow
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic [2:0] sel_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         sel_q <= 3'h7;
      else
         sel_q <= digit_sel_n;
   end

   sequence s_mr_held;
      master_reset [*2];
   endsequence
   sequence s_mr_release;
      master_reset ##1 !master_reset;
   endsequence

   a_sel_legal: assert property (
      digit_sel_n inside {3'h6, 3'h5, 3'h3, 3'h7})
      else $error("digit select not one-hot");
   a_mr_blank: assert property (s_mr_held |-> digit_sel_n == 3'h7)
      else $error("select active during master reset");
   a_mr_restart: assert property (
      s_mr_release |-> ##[0:1] digit_sel_n == 3'h6)
      else $error("scan not restarted at units");
   a_ovf_single: assert property (overflow |=> !overflow)
      else $error("overflow longer than one cycle");
   a_ovf_cause: assert property (overflow |->
      $past(count_clk, 2) && !$past(count_clk) && !$past(master_reset))
      else $error("overflow without a counted edge");
   a_dis_block: assert property ($past(count_disable) |-> !overflow)
      else $error("count passed while disabled");
   a_scan_order: assert property (
      digit_sel_n != sel_q && sel_q != 3'h7 && digit_sel_n != 3'h7
      |-> digit_sel_n == {sel_q[1:0], sel_q[2]})
      else $error("scan order wrong");
   a_latch_hold: assert property (
      $past(latch_enable, 2) && $stable(digit_sel_n) && digit_sel_n != 3'h7
      |-> $stable(bcd_out))
      else $error("held digit changed");
endmodule

bind tdbc_counter_top tdbc_checker chk_u (.hclk(hclk), .hresetn(hresetn),
   .count_clk(count_clk), .count_disable(count_disable),
   .master_reset(master_reset), .latch_enable(latch_enable),
   .bcd_out(bcd_out), .digit_sel_n(digit_sel_n), .overflow(overflow));

`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none

`include "tdbc_regs.svh"

module tb;
   import tdbc_pkg::*;
   localparam int LIMIT = 20000;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, overflow;
   logic count_clk, count_disable, master_reset, latch_enable;
   logic ext_scan_clk, ext_run, ce;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, digit_sel_n;
   logic [3:0] bcd_out;
   tdbc_count_t shown;
   int steps, wraps, n1, n2, s0;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;

   tdbc_counter_top dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .count_clk(count_clk), .count_disable(count_disable),
      .master_reset(master_reset), .latch_enable(latch_enable),
      .ext_scan_clk(ext_scan_clk), .bcd_out(bcd_out),
      .digit_sel_n(digit_sel_n), .overflow(overflow));
   tdbc_disp_model disp_u (.hclk(hclk), .bcd_out(bcd_out),
      .digit_sel_n(digit_sel_n), .overflow(overflow), .ext_run(ext_run),
      .ext_scan_clk(ext_scan_clk), .shown(shown), .steps(steps),
      .wraps(wraps));

   function automatic logic [31:0] bcd(input int v);
      return {20'h0, 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
   endfunction

   task automatic summarize();
      $display("Comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic xfer(input logic [31:0] a, input logic w,
                       input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task automatic rdc(input string nm, input logic [31:0] a, e);
      xfer(a, 1'b0, 32'h0);
      chk(nm, e, rd);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   // Model reads its tally one edge late, hence three idle edges
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge hclk);
         count_clk <= 1'b1;
         @(posedge hclk);
         count_clk <= 1'b0;
      end
      repeat (3) @(posedge hclk);
   endtask

   task automatic mr_pulse();
      @(posedge hclk);
      master_reset <= 1'b1;
      repeat (3) @(posedge hclk);
      master_reset <= 1'b0;
      repeat (2) @(posedge hclk);
   endtask

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         num_errors++;
         summarize();
      end
   end

   initial begin
      {hresetn, hsel, hwrite, count_clk, count_disable} = '0;
      {master_reset, latch_enable, ext_run, htrans} = '0;
      {haddr, hwdata, rd} = '0;
      hsize = 3'h2;
      ce = 1'b1;
      s0 = $urandom(25876);
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rdc("ctrl", `TDBC_CTRL_OFS, 32'h0);
      rdc("scan_div", `TDBC_SCAN_DIV_OFS, 32'h0FA0);
      rdc("wraps", `TDBC_WRAPS_OFS, 32'h0);
      rdc("hole", 32'h18, 32'h0);
      xfer(`TDBC_SCAN_DIV_OFS, 1'b1, 32'h3);
      rdc("scan_div_wr", `TDBC_SCAN_DIV_OFS, 32'h3);
      n1 = $urandom_range(499, 1);
      n2 = $urandom_range(499, 1);
      mr_pulse();
      pulse(n1);
      latch_enable <= 1'b1;
      pulse(n2);
      rdc("count", `TDBC_COUNT_OFS, bcd(n1 + n2));
      rdc("latch_hold", `TDBC_LATCH_OFS, bcd(n1));
      repeat (30) @(posedge hclk);
      for (int i = 0; i < 3; i++) begin
         rd = (bcd(n1) >> (4 * i)) & 32'hF;
         chk("shown", rd, {28'h0, shown[i]});
      end
      mr_pulse();
      rdc("count_mr", `TDBC_COUNT_OFS, 32'h0);
      rdc("latch_mr", `TDBC_LATCH_OFS, bcd(n1));
      latch_enable <= 1'b0;
      pulse(7);
      rdc("latch_follow", `TDBC_LATCH_OFS, bcd(7));
      count_disable <= 1'b1;
      pulse(5);
      count_disable <= 1'b0;
      rdc("count_dis", `TDBC_COUNT_OFS, bcd(7));
      // Clock enable low freezes the counters as well
      ce <= 1'b0;
      pulse(4);
      ce <= 1'b1;
      rdc("count_ce", `TDBC_COUNT_OFS, bcd(7));
      xfer(`TDBC_SCAN_DIV_OFS, 1'b1, 32'hFFFF);
      xfer(`TDBC_CTRL_OFS, 1'b1, 32'h8);
      s0 = steps;
      ext_run <= 1'b1;
      repeat (48) @(posedge hclk);
      ext_run <= 1'b0;
      repeat (4) @(posedge hclk);
      chk("ext_steps", 32'd6, 32'(steps - s0));
      // Soft reset, disable and latch; scanner must stay parked
      xfer(`TDBC_SCAN_DIV_OFS, 1'b1, 32'h3);
      xfer(`TDBC_CTRL_OFS, 1'b1, 32'h7);
      repeat (20) @(posedge hclk);
      rdc("status_mr", `TDBC_STATUS_OFS, 32'h707);
      rdc("count_soft", `TDBC_COUNT_OFS, 32'h0);
      xfer(`TDBC_CTRL_OFS, 1'b1, 32'h0);
      mr_pulse();
      s0 = wraps;
      pulse(999);
      chk("no_wrap", 32'(s0), 32'(wraps));
      pulse(1);
      chk("one_wrap", 32'(s0 + 1), 32'(wraps));
      rdc("count_wrap", `TDBC_COUNT_OFS, 32'h0);
      rdc("wraps_reg", `TDBC_WRAPS_OFS, 32'h1);
      xfer(`TDBC_WRAPS_OFS, 1'b1, 32'h0);
      rdc("wraps_clr", `TDBC_WRAPS_OFS, 32'h0);
      summarize();
   end
endmodule

`default_nettype wire
